// File: hw/pecsr_defs.svh
// offsets, field positions, reset values of the port low power control register
// assumes: included by the package and by the design module
`ifndef PECSR_DEFS_SVH
`define PECSR_DEFS_SVH

// ----------------------------------------
// direct byte registers
// ----------------------------------------
`define PECSR_ADDR_SELECT   8'h6E
`define PECSR_ADDR_OFFSET   8'h6F
`define PECSR_ADDR_DATA     8'hA0

// ----------------------------------------
// select register fields
// ----------------------------------------
`define PECSR_SEL_TABLE_HI  7
`define PECSR_SEL_TABLE_LO  5
`define PECSR_SEL_DIR_BIT   4
`define PECSR_SEL_PORT_HI   3
`define PECSR_SEL_PORT_LO   0
`define PECSR_TABLE_LOWPWR  3'h1
`define PECSR_PORT_FIRST    4'h1
`define PECSR_PORT_LAST     4'h3

// ----------------------------------------
// indirect offsets of the control register
// ----------------------------------------
`define PECSR_OFS_HI        8'h2C
`define PECSR_OFS_LO        8'h2D

// ----------------------------------------
// field positions (16-bit view)
// ----------------------------------------
`define PECSR_BIT_TEN_OFF   15
`define PECSR_BIT_HW_NP     7
`define PECSR_BIT_HW_STAT   6
`define PECSR_BIT_TX_STICKY 5
`define PECSR_BIT_TX_NOW    4
`define PECSR_BIT_RX_STICKY 3
`define PECSR_BIT_RX_NOW    2
`define PECSR_BIT_SW_MODE   1
`define PECSR_BIT_SW_FAST   0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PECSR_RST_TEN_OFF   1'b1
`define PECSR_RST_HW_NP     1'b1
`define PECSR_RST_CLEAR     1'b0
`define PECSR_RST_BYTE      8'h00

`endif

// File: hw/pecsr_pkg.sv
// types shared by the port low power control register bank
// assumes: pecsr_defs.svh on the include path
package pecsr_pkg;
  `include "pecsr_defs.svh"

  typedef logic [7:0]  pecsr_byte_t;
  typedef logic [15:0] pecsr_word_t;
  typedef logic [3:0]  pecsr_port_t;
endpackage

// File: hw/pecsr_top.sv
// per-port low power control/status register, reached through the indirect byte window
// assumes: byte register strobes and idle indications come from logic on clk
//
// Operation
// - The upper byte sits at indirect offset 0x2C and the lower byte at 0x2D.
// - Writing the offset register starts the access and the byte moves through the data byte.
// - Bit 15 is read-write, one turns 10BASE-T low power off, reset value one.
// - Bit 7 lets hardware negotiate low power by next pages, reset value one.
// - Bit 6 is read-only and shows hardware negotiation enabled 100BASE-TX low power.
// - Bit 5 latches transmit idle signaling since the last read and clears on read.
// - Bit 4 shows the live transmit idle indication without latching.
// - Bit 3 latches receive idle signaling since the last read and clears on read.
// - Bit 2 shows the live receive idle indication, reset value zero.
// - Bit 1 selects software mode, where bit 0 governs low power, reset value zero.
// - Bit 0 is the read-write 100BASE-TX low power enable, reset value zero.
// - With hardware negotiation enabled, hardware may also set bit 0.
`timescale 1ns/1ps
`include "pecsr_defs.svh"

module pecsr_top
  import pecsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // byte register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // pcs and negotiation status, index = port number
  input  wire logic [3:1]  tx_idle_in,
  input  wire logic [3:1]  rx_idle_in,
  input  wire logic [3:1]  hw_nego_fast_ok,
  // control towards the phy
  output logic      [3:1]  ten_meg_lowpower_off,
  output logic      [3:1]  hw_nextpage_lowpower_negotiate,
  output logic      [3:1]  sw_lowpower_mode_on,
  output logic      [3:1]  sw_fast_lowpower_on,
  output logic      [3:1]  fast_lowpower_active
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // true when select/offset name this register of port p at byte ofs
  function automatic logic sel_hit(input pecsr_byte_t sel, input pecsr_byte_t off,
                                   input pecsr_port_t p, input pecsr_byte_t ofs);
    sel_hit = (sel[`PECSR_SEL_TABLE_HI:`PECSR_SEL_TABLE_LO] == `PECSR_TABLE_LOWPWR)
           && (sel[`PECSR_SEL_PORT_HI:`PECSR_SEL_PORT_LO] == p)
           && (off == ofs);
  endfunction

  pecsr_byte_t select_q;
  pecsr_byte_t offset_q;
  pecsr_byte_t data_q;

  wire wr_select = reg_wr && (reg_addr == `PECSR_ADDR_SELECT);
  wire wr_offset = reg_wr && (reg_addr == `PECSR_ADDR_OFFSET);
  wire wr_data   = reg_wr && (reg_addr == `PECSR_ADDR_DATA);
  wire dir_read  = select_q[`PECSR_SEL_DIR_BIT];

  // ----------------------------------------
  // select and offset registers
  // ----------------------------------------
  // table code held in select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      select_q <= `PECSR_RST_BYTE;
    end else if (wr_select) begin
      select_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_q <= `PECSR_RST_BYTE;
    end else if (wr_offset) begin
      offset_q <= reg_wdata;
    end
  end

  // fetch happens on the offset write, using the new offset byte
  wire fetch = wr_offset && dir_read;

  // ----------------------------------------
  // per-port register copies
  // ----------------------------------------
  logic [3:1]  tx_sticky;
  logic [3:1]  rx_sticky;
  logic [3:1]  tx_now;
  logic [3:1]  rx_now;
  logic [3:1]  hw_stat;
  logic [7:0]  hi_byte [3:1];
  logic [7:0]  lo_byte [3:1];
  logic [3:1]  fetch_hi;
  logic [3:1]  fetch_lo;
  logic [3:1]  store_hi;
  logic [3:1]  store_lo;

  genvar gp;
  generate
    for (gp = 1; gp <= 3; gp = gp + 1) begin : g_port
      localparam pecsr_port_t PNUM = pecsr_port_t'(gp);

      assign fetch_hi[gp] = fetch && sel_hit(select_q, reg_wdata, PNUM, `PECSR_OFS_HI);
      assign fetch_lo[gp] = fetch && sel_hit(select_q, reg_wdata, PNUM, `PECSR_OFS_LO);
      // write commits on the data byte
      assign store_hi[gp] = wr_data && !dir_read
                          && sel_hit(select_q, offset_q, PNUM, `PECSR_OFS_HI);
      assign store_lo[gp] = wr_data && !dir_read
                          && sel_hit(select_q, offset_q, PNUM, `PECSR_OFS_LO);

      assign hi_byte[gp] = {ten_meg_lowpower_off[gp], 7'h00};
      assign lo_byte[gp] = {hw_nextpage_lowpower_negotiate[gp], hw_stat[gp],
                            tx_sticky[gp], tx_now[gp], rx_sticky[gp], rx_now[gp],
                            sw_lowpower_mode_on[gp], sw_fast_lowpower_on[gp]};

      // hardware sets bit 0 once, when negotiation first reports success
      wire hw_set_fast = hw_nextpage_lowpower_negotiate[gp] && hw_nego_fast_ok[gp]
                      && !hw_stat[gp];

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ten_meg_lowpower_off[gp] <= `PECSR_RST_TEN_OFF;
        end else if (store_hi[gp]) begin
          ten_meg_lowpower_off[gp] <= reg_wdata[`PECSR_BIT_TEN_OFF - 8];
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          hw_nextpage_lowpower_negotiate[gp] <= `PECSR_RST_HW_NP;
          sw_lowpower_mode_on[gp]            <= `PECSR_RST_CLEAR;
        end else if (store_lo[gp]) begin
          hw_nextpage_lowpower_negotiate[gp] <= reg_wdata[`PECSR_BIT_HW_NP];
          sw_lowpower_mode_on[gp]            <= reg_wdata[`PECSR_BIT_SW_MODE];
        end
      end

      // hardware set wins over a software write
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sw_fast_lowpower_on[gp] <= `PECSR_RST_CLEAR;
        end else if (hw_set_fast) begin
          sw_fast_lowpower_on[gp] <= 1'b1;
        end else if (store_lo[gp]) begin
          sw_fast_lowpower_on[gp] <= reg_wdata[`PECSR_BIT_SW_FAST];
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          hw_stat[gp] <= `PECSR_RST_CLEAR;
          tx_now[gp]  <= `PECSR_RST_CLEAR;
          rx_now[gp]  <= `PECSR_RST_CLEAR;
        end else begin
          hw_stat[gp] <= hw_nextpage_lowpower_negotiate[gp] && hw_nego_fast_ok[gp];
          tx_now[gp]  <= tx_idle_in[gp];
          rx_now[gp]  <= rx_idle_in[gp];
        end
      end

      // transmit sticky, clear on fetch, set wins
      // receive sticky, clear on fetch, set wins
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          tx_sticky[gp] <= `PECSR_RST_CLEAR;
          rx_sticky[gp] <= `PECSR_RST_CLEAR;
        end else begin
          tx_sticky[gp] <= tx_idle_in[gp] || (tx_sticky[gp] && !fetch_lo[gp]);
          rx_sticky[gp] <= rx_idle_in[gp] || (rx_sticky[gp] && !fetch_lo[gp]);
        end
      end

      // effective 100BASE-TX enable seen by the phy
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          fast_lowpower_active[gp] <= `PECSR_RST_CLEAR;
        end else begin
          fast_lowpower_active[gp] <= sw_lowpower_mode_on[gp] ? sw_fast_lowpower_on[gp]
                                                               : hw_stat[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // data byte register
  // ----------------------------------------
  // untargeted fetches load zero so stale data never looks valid
  logic [7:0] fetch_byte;
  always_comb begin
    fetch_byte = 8'h00;
    for (int i = 1; i <= 3; i++) begin
      if (fetch_hi[i]) fetch_byte = hi_byte[i];
      if (fetch_lo[i]) fetch_byte = lo_byte[i];
    end
  end

  // byte transferred through the data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= `PECSR_RST_BYTE;
    end else if (fetch) begin
      data_q <= fetch_byte;
    end else if (wr_data) begin
      data_q <= reg_wdata;
    end
  end

  // ----------------------------------------
  // read return
  // ----------------------------------------
  wire [7:0] rd_mux = (reg_addr == `PECSR_ADDR_SELECT) ? select_q :
                      (reg_addr == `PECSR_ADDR_OFFSET) ? offset_q :
                      (reg_addr == `PECSR_ADDR_DATA)   ? data_q   : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= `PECSR_RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// File: sim/pecsr_asserts.sv
// assertions on the ports of the port low power control register
// assumes: bound to pecsr_top; select and offset are shadowed here
`timescale 1ns/1ps
`include "pecsr_defs.svh"
module pecsr_asserts
  import pecsr_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // byte register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // status and control
  input wire logic [3:1] tx_idle_in,
  input wire logic [3:1] rx_idle_in,
  input wire logic [3:1] hw_nego_fast_ok,
  input wire logic [3:1] ten_meg_lowpower_off,
  input wire logic [3:1] hw_nextpage_lowpower_negotiate,
  input wire logic [3:1] sw_lowpower_mode_on,
  input wire logic [3:1] sw_fast_lowpower_on,
  input wire logic [3:1] fast_lowpower_active
);
  // ----------------------------------------
  // shadow of select and offset
  // ----------------------------------------
  logic [7:0] sel_q;
  logic [7:0] ofs_q;
  logic [1:0] p;
  logic       wr_hit;
  logic       wr_hi;
  logic       wr_lo;
  assign p      = sel_q[1:0];
  assign wr_hit = reg_wr && reg_addr == 8'hA0 && sel_q[7:4] == 4'h2
                  && sel_q[3:2] == 2'h0 && p != 2'h0;
  assign wr_hi  = wr_hit && ofs_q == 8'h2C;
  assign wr_lo  = wr_hit && ofs_q == 8'h2D;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= 8'h00;
      ofs_q <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h6E) begin
      sel_q <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h6F) begin
      ofs_q <= reg_wdata;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid not one cycle after read");
  property p_rdata_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without read");
  property p_ten_wr; wr_hi |=> ten_meg_lowpower_off[p] == $past(reg_wdata[7]); endproperty
  a_ten_wr: assert property (p_ten_wr) else $error("bit 15 write lost");
  property p_ten_hold; !$past(wr_hi) |-> $stable(ten_meg_lowpower_off); endproperty
  a_ten_hold: assert property (p_ten_hold) else $error("bit 15 changed unasked");
  property p_np_wr;
    wr_lo |=> hw_nextpage_lowpower_negotiate[p] == $past(reg_wdata[7])
              && sw_lowpower_mode_on[p] == $past(reg_wdata[1]);
  endproperty
  a_np_wr: assert property (p_np_wr) else $error("low byte write lost");
  property p_mode_hold; !$past(wr_lo) |-> $stable(sw_lowpower_mode_on); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode bit changed unasked");
  property p_active;
    (fast_lowpower_active & $past(sw_lowpower_mode_on))
      == $past(sw_lowpower_mode_on & sw_fast_lowpower_on);
  endproperty
  a_active: assert property (p_active) else $error("active not from bit 0");
  property p_hw_set;
    hw_nextpage_lowpower_negotiate[1] && hw_nego_fast_ok[1]
      && !$past(hw_nextpage_lowpower_negotiate[1] && hw_nego_fast_ok[1])
      |=> sw_fast_lowpower_on[1];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("hardware did not set bit 0");
  c_read: cover property (reg_rvalid);
  c_hi: cover property (wr_hi);
  c_hw: cover property (hw_nextpage_lowpower_negotiate[1] && hw_nego_fast_ok[1]);
endmodule

// File: sim/test_pecsr_top.sv
// self-checking bench for the port low power control register
// assumes: design and checker compiled before this file
`timescale 1ns/1ps
module test_pecsr_top
  import pecsr_pkg::*;
();
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [3:1]  tx_idle_in = 3'h0;
  logic [3:1]  rx_idle_in = 3'h0;
  logic [3:1]  ok = 3'h0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [3:1]  ten;
  logic [3:1]  np;
  logic [3:1]  mode;
  logic [3:1]  fast;
  logic [3:1]  act;
  pecsr_byte_t d;
  int          err_total = 0;
  int          checks = 0;
  always #2.5 clk = ~clk;
  pecsr_top u_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .tx_idle_in(tx_idle_in), .rx_idle_in(rx_idle_in),
    .hw_nego_fast_ok(ok), .ten_meg_lowpower_off(ten),
    .hw_nextpage_lowpower_negotiate(np), .sw_lowpower_mode_on(mode),
    .sw_fast_lowpower_on(fast), .fast_lowpower_active(act));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({7'h0, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask
  // data byte is fetched at the offset write, so select goes first
  task ird(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e);
    wr(8'h6E, {3'h1, 1'b1, p});
    wr(8'h6F, o);
    rd(8'hA0);
    chk(d, e);
  endtask
  task iwr(input logic [3:0] p, input logic [7:0] o, input logic [7:0] v);
    wr(8'h6E, {3'h1, 1'b0, p});
    wr(8'h6F, o);
    wr(8'hA0, v);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    for (int p = 1; p <= 3; p++) begin
      ird(p[3:0], 8'h2C, 8'h80);
      ird(p[3:0], 8'h2D, 8'h80);
    end
    chk({2'h0, ten, np}, 8'h3F);
    chk({2'h0, mode, fast}, 8'h00);
  endtask
  task t_write;
    iwr(4'h2, 8'h2C, 8'hFF);
    ird(4'h2, 8'h2C, 8'h80);
    iwr(4'h2, 8'h2C, 8'h00);
    ird(4'h2, 8'h2C, 8'h00);
    iwr(4'h2, 8'h2D, 8'h03);
    @(negedge clk);
    chk({2'h0, ten, np}, 8'h2D);
    chk({2'h0, mode, fast}, 8'h12);
    chk({5'h0, act}, 8'h02);
    ird(4'h2, 8'h2D, 8'h03);
  endtask
  task t_refuse;
    wr(8'h6E, 8'h41);
    wr(8'h6F, 8'h2C);
    wr(8'hA0, 8'h00);
    iwr(4'h0, 8'h2C, 8'h00);
    iwr(4'h1, 8'h2E, 8'h00);
    chk({5'h0, ten}, 8'h05);
    ird(4'h0, 8'h2C, 8'h00);
    rd(8'h55);
    chk(d, 8'h00);
  endtask
  task t_idle;
    @(negedge clk);
    tx_idle_in = 3'h4;
    rx_idle_in = 3'h4;
    @(negedge clk);
    tx_idle_in = 3'h0;
    repeat (2) @(negedge clk);
    ird(4'h3, 8'h2D, 8'hAC);
    ird(4'h3, 8'h2D, 8'h8C);
    rx_idle_in = 3'h0;
    repeat (2) @(negedge clk);
    ird(4'h3, 8'h2D, 8'h88);
    ird(4'h3, 8'h2D, 8'h80);
  endtask
  task t_hw;
    @(negedge clk);
    ok = 3'h1;
    repeat (3) @(negedge clk);
    chk({7'h0, fast[1]}, 8'h01);
    chk({7'h0, act[1]}, 8'h01);
    ird(4'h1, 8'h2D, 8'hC1);
  endtask
  task conclude;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    t_reset;
    t_write;
    t_refuse;
    t_idle;
    t_hw;
    conclude;
  end
  // under two hundred cycles of traffic, far below the watchdog
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
bind pecsr_top pecsr_asserts u_chk (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .tx_idle_in(tx_idle_in), .rx_idle_in(rx_idle_in),
  .hw_nego_fast_ok(hw_nego_fast_ok), .ten_meg_lowpower_off(ten_meg_lowpower_off),
  .hw_nextpage_lowpower_negotiate(hw_nextpage_lowpower_negotiate),
  .sw_lowpower_mode_on(sw_lowpower_mode_on), .sw_fast_lowpower_on(sw_fast_lowpower_on),
  .fast_lowpower_active(fast_lowpower_active));
